// ===== core/dtbls_defines.svh
// constants for the data transfer bus byte lane selector
`ifndef DTBLS_DEFINES_SVH
`define DTBLS_DEFINES_SVH

// clock period in ns
`define DTBLS_CLK_NS 5
// least settle time of the lane select lines, ns
`define DTBLS_SETTLE_NS 20
// settle count, rounded up to whole cycles
`define DTBLS_SETTLE_CYC \
  ((`DTBLS_SETTLE_NS + `DTBLS_CLK_NS - 1) / `DTBLS_CLK_NS)
// bus timer limit in us and in cycles (rounded down)
`define DTBLS_BTO_US 64
`define DTBLS_BTO_CYC ((`DTBLS_BTO_US * 1000) / `DTBLS_CLK_NS)

// byte lane masks, bit n is byte location n
`define DTBLS_LANES_RST 4'h0
`define DTBLS_LANE_B0 4'h1
`define DTBLS_LANE_B1 4'h2
`define DTBLS_LANE_B2 4'h4
`define DTBLS_LANE_B3 4'h8
`define DTBLS_LANE_B01 4'h3
`define DTBLS_LANE_B23 4'hC
`define DTBLS_LANE_B02 4'h7
`define DTBLS_LANE_B13 4'hE
`define DTBLS_LANE_B12 4'h6
`define DTBLS_LANE_ALL 4'hF

`endif

// ===== core/dtbls_pkg.sv
// types for the data transfer bus byte lane selector
package dtbls_pkg;

  // backplane lines seen by the slave, all low-true except a01/addr
  typedef struct packed {
    logic as_n;
    logic ds1_n;
    logic ds0_n;
    logic a01;
    logic lword_n;
    logic dtack_n;
    logic berr_n;
    logic [29:0] addr;
  } dtbls_pins_s;

  // block mode from the on-board address modifier decoder
  typedef enum logic [1:0] {
    BLK_NONE,
    BLK_BYTE,
    BLK_DBL
  } dtbls_blk_e;

  // on-board settings, same clock domain
  typedef struct packed {
    dtbls_blk_e blk;
    logic [29:0] mon_base;
    logic [29:0] mon_mask;
    logic [3:0] mon_lanes;
  } dtbls_cfg_s;

  // kind of the decoded transfer
  typedef enum logic [2:0] {
    CYC_NONE,
    CYC_SINGLE,
    CYC_DOUBLE,
    CYC_TRIPLE,
    CYC_QUAD,
    CYC_BLK_BYTE,
    CYC_BLK_DBL
  } dtbls_cyc_e;

  // transfer tracker states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_HOLD
  } dtbls_st_e;

endpackage : dtbls_pkg

// ===== core/dtbls_sync.sv
// two-stage synchroniser with a settle detector
`timescale 1ns/1ps
module dtbls_sync #(
  parameter int W = 37,
  parameter int SETTLE = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // raw and synchronised lines
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic stable
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [$clog2(SETTLE+1)-1:0] cnt_reg;

  // two flip-flops before any logic looks at the lines
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_reg <= '1;
      s2_reg <= '1;
      q <= '1;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      q <= s2_reg;
    end
  end

  // count cycles since the lines last moved
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
      stable <= 1'b0;
    end else if (s2_reg != q) begin
      cnt_reg <= '0;
      stable <= 1'b0;
    end else if (cnt_reg != SETTLE[$clog2(SETTLE+1)-1:0]) begin
      cnt_reg <= cnt_reg + 1'b1;
      stable <= (cnt_reg == SETTLE[$clog2(SETTLE+1)-1:0] - 1'b1);
    end
  end
endmodule : dtbls_sync

// ===== core/dtbls_lane_select.sv
// slave byte lane decoder, bus timer and location monitor
`timescale 1ns/1ps
`include "dtbls_defines.svh"

// Summary of operation
// - the two low address bits name byte 0, 1, 2 or 3 of a group.
// - both strobes, a01 and lword_n together pick one to four bytes.
// - address-only cycles keep both strobes high; no byte is picked.
// - ds1 low, ds0 high, lword high picks byte 0 or 2 by a01.
// - ds1 high, ds0 low, lword high picks byte 1 or 3 by a01.
// - both strobes low, lword high picks bytes 0-1 or 2-3 by a01.
// - all four lines low pick the whole group.
// - single-byte blocks hold lword high; strobes alternate per byte.
// - first block strobe names the start byte; a01 valid to first ack.
// - double-byte blocks keep both strobes low; a01 gives start pair.
// - double-byte block a01 valid only until first ack or bus error.
// - quad-byte blocks drive all four lines low each transfer.
// - single-byte read-modify-write uses single-byte levels.
// - double and quad read-modify-write use the plain transfer levels.
// - unaligned cycles with lword low pick bytes 0-2, 1-3 or 1-2.
// - the slave may treat both illegal combinations as bytes 1-2.
// - the slave decodes from settled levels, never from skew states.
// - the slave may take as long as it needs to answer.
// - a bus timer ends cycles that no slave answers.
// - a location monitor flags access to the bytes it watches.
module dtbls_lane_select #(
  parameter int SETTLE_CYC = `DTBLS_SETTLE_CYC,
  parameter int BTO_CYC = `DTBLS_BTO_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // backplane lines, asynchronous
  input wire dtbls_pkg::dtbls_pins_s bus_pins,
  // on-board settings
  input wire dtbls_pkg::dtbls_cfg_s cfg,
  // decoded transfer
  output logic [3:0] lane_en,
  output logic xfer_start,
  output logic xfer_active,
  output dtbls_pkg::dtbls_cyc_e cyc_kind,
  output logic [29:0] xfer_addr,
  output logic illegal_seen,
  // bus error line, open drain
  output logic berr_out,
  output logic berr_oe,
  // location monitor
  output logic mon_hit
);
  localparam int BW = $clog2(BTO_CYC + 1);

  dtbls_pkg::dtbls_pins_s sy;
  logic stable;
  dtbls_pkg::dtbls_st_e st_reg;
  logic first_reg;
  logic [1:0] ptr_reg;
  logic [BW-1:0] bt_cnt_reg;
  logic mon_chk_reg;
  logic as_act;
  logic ds_any;
  logic start_go;
  logic bt_run;
  logic [3:0] dec_lanes;
  logic [3:0] lanes_next;
  logic [1:0] cur_pos;
  logic [1:0] ptr_next;
  dtbls_pkg::dtbls_cyc_e kind_next;

  // lines pass three flops and a settle filter before decode
  dtbls_sync #(
    .W($bits(dtbls_pkg::dtbls_pins_s)),
    .SETTLE(SETTLE_CYC)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(bus_pins),
    .q(sy),
    .stable(stable)
  );

  // lane mask from the four select lines
  function automatic logic [3:0] decode_lanes(
    input logic ds1_n,
    input logic ds0_n,
    input logic a01,
    input logic lword_n
  );
    logic [3:0] m;
    m = `DTBLS_LANES_RST;
    if (ds1_n && ds0_n) begin
      m = `DTBLS_LANES_RST;
    end else if (lword_n) begin
      if (!ds1_n && ds0_n) begin
        m = a01 ? `DTBLS_LANE_B2 : `DTBLS_LANE_B0;
      end else if (ds1_n && !ds0_n) begin
        m = a01 ? `DTBLS_LANE_B3 : `DTBLS_LANE_B1;
      end else begin
        m = a01 ? `DTBLS_LANE_B23 : `DTBLS_LANE_B01;
      end
    end else if (a01) begin
      m = `DTBLS_LANE_B12;
    end else if (!ds1_n && !ds0_n) begin
      m = `DTBLS_LANE_ALL;
    end else if (!ds1_n) begin
      m = `DTBLS_LANE_B02;
    end else begin
      m = `DTBLS_LANE_B13;
    end
    return m;
  endfunction : decode_lanes

  // lowest byte position in a mask
  function automatic logic [1:0] low_pos(input logic [3:0] m);
    logic [1:0] p;
    p = 2'h0;
    if (m[0]) begin
      p = 2'h0;
    end else if (m[1]) begin
      p = 2'h1;
    end else if (m[2]) begin
      p = 2'h2;
    end else if (m[3]) begin
      p = 2'h3;
    end
    return p;
  endfunction : low_pos

  // number of bytes in a mask, as a transfer kind
  function automatic dtbls_pkg::dtbls_cyc_e size_kind(
    input logic [3:0] m
  );
    dtbls_pkg::dtbls_cyc_e k;
    case (m)
      `DTBLS_LANE_B0, `DTBLS_LANE_B1,
      `DTBLS_LANE_B2, `DTBLS_LANE_B3: k = dtbls_pkg::CYC_SINGLE;
      `DTBLS_LANE_B01, `DTBLS_LANE_B23,
      `DTBLS_LANE_B12: k = dtbls_pkg::CYC_DOUBLE;
      `DTBLS_LANE_B02, `DTBLS_LANE_B13: k = dtbls_pkg::CYC_TRIPLE;
      `DTBLS_LANE_ALL: k = dtbls_pkg::CYC_QUAD;
      default: k = dtbls_pkg::CYC_NONE;
    endcase
    return k;
  endfunction : size_kind

  // bus condition terms
  assign as_act = !sy.as_n;
  assign ds_any = !sy.ds1_n || !sy.ds0_n;
  assign start_go = (st_reg == dtbls_pkg::ST_IDLE) && as_act && ds_any &&
    stable;
  assign bt_run = as_act && ds_any && sy.dtack_n && sy.berr_n;
  // byte position bits equal the two low address bits
  assign dec_lanes = decode_lanes(sy.ds1_n, sy.ds0_n, sy.a01,
    sy.lword_n);

  // pick lanes: decoded on a first or plain transfer, stepped in blocks
  always_comb begin
    lanes_next = dec_lanes;
    kind_next = size_kind(dec_lanes);
    cur_pos = first_reg ? low_pos(dec_lanes) : ptr_reg;
    ptr_next = cur_pos;
    case (cfg.blk)
      dtbls_pkg::BLK_BYTE: begin
        // a01 counts only on the first transfer of the block
        if (!first_reg) begin
          lanes_next = 4'(`DTBLS_LANE_B0 << cur_pos);
        end
        ptr_next = cur_pos + 2'h1;
        kind_next = dtbls_pkg::CYC_BLK_BYTE;
      end
      dtbls_pkg::BLK_DBL: begin
        if (!first_reg) begin
          lanes_next = cur_pos[1] ? `DTBLS_LANE_B23 :
            `DTBLS_LANE_B01;
        end
        ptr_next = cur_pos + 2'h2;
        kind_next = dtbls_pkg::CYC_BLK_DBL;
      end
      default: begin
        // quad blocks and read-modify-write decode every transfer
        lanes_next = dec_lanes;
      end
    endcase
  end

  // transfer tracker: idle until settled strobes, hold until release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg <= dtbls_pkg::ST_IDLE;
    end else begin
      case (st_reg)
        dtbls_pkg::ST_IDLE: begin
          if (start_go) begin
            st_reg <= dtbls_pkg::ST_HOLD;
          end
        end
        dtbls_pkg::ST_HOLD: begin
          if (!as_act || (!ds_any && stable)) begin
            st_reg <= dtbls_pkg::ST_IDLE;
          end
        end
        default: st_reg <= dtbls_pkg::ST_IDLE;
      endcase
    end
  end

  // first transfer flag: armed with address strobe high, ends at first ack
  always_ff @(posedge clk) begin
    if (!rstn) begin
      first_reg <= 1'b1;
    end else if (!as_act) begin
      first_reg <= 1'b1;
    end else if (!sy.dtack_n || !sy.berr_n) begin
      first_reg <= 1'b0;
    end
  end

  // next block byte position
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ptr_reg <= 2'h0;
    end else if (start_go) begin
      ptr_reg <= ptr_next;
    end
  end

  // lane enables, kind and group address, held through the transfer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lane_en <= `DTBLS_LANES_RST;
      xfer_active <= 1'b0;
      cyc_kind <= dtbls_pkg::CYC_NONE;
      xfer_addr <= '0;
    end else if (start_go) begin
      lane_en <= lanes_next;
      xfer_active <= 1'b1;
      cyc_kind <= kind_next;
      xfer_addr <= sy.addr;
    end else if (st_reg == dtbls_pkg::ST_HOLD &&
        (!as_act || (!ds_any && stable))) begin
      lane_en <= `DTBLS_LANES_RST;
      xfer_active <= 1'b0;
      cyc_kind <= dtbls_pkg::CYC_NONE;
    end
  end

  // start pulse and settled-illegal flag
  always_ff @(posedge clk) begin
    if (!rstn) begin
      xfer_start <= 1'b0;
      illegal_seen <= 1'b0;
    end else begin
      xfer_start <= start_go;
      illegal_seen <= start_go && first_reg && !sy.lword_n && sy.a01 &&
        (sy.ds1_n != sy.ds0_n);
    end
  end

  // bus timer; no slave deadline below this long limit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bt_cnt_reg <= '0;
    end else if (bt_run && !berr_oe) begin
      bt_cnt_reg <= bt_cnt_reg + 1'b1;
    end else begin
      bt_cnt_reg <= '0;
    end
  end

  // drive bus error low once the limit is reached, until strobes rise
  always_ff @(posedge clk) begin
    if (!rstn) begin
      berr_oe <= 1'b0;
      berr_out <= 1'b0;
    end else begin
      berr_out <= 1'b0;
      if (bt_run && bt_cnt_reg == BW'(BTO_CYC - 1)) begin
        berr_oe <= 1'b1;
      end else if (!ds_any) begin
        berr_oe <= 1'b0;
      end
    end
  end

  // location monitor: compare group and lanes one cycle after start
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mon_chk_reg <= 1'b0;
      mon_hit <= 1'b0;
    end else begin
      mon_chk_reg <= start_go;
      mon_hit <= mon_chk_reg &&
        (((xfer_addr ^ cfg.mon_base) & ~cfg.mon_mask) == 30'h0) &&
        ((lane_en & cfg.mon_lanes) != 4'h0);
    end
  end

  // lanes stay off while idle with both strobes high
  a_idle_lanes_off: assert property (
    @(posedge clk) disable iff (!rstn)
    st_reg == dtbls_pkg::ST_IDLE && sy.ds1_n && sy.ds0_n |=>
    lane_en == 4'h0 && !xfer_active)
    else $error("lane enables on outside a transfer");

  // quad select
  a_quad_decode: assert property (
    @(posedge clk) disable iff (!rstn)
    start_go && cfg.blk == dtbls_pkg::BLK_NONE && !sy.ds1_n &&
    !sy.ds0_n && !sy.a01 && !sy.lword_n |=> lane_en == 4'hF)
    else $error("quad select not decoded to all lanes");

  // both illegal combinations read as bytes 1-2
  a_illegal_mid: assert property (
    @(posedge clk) disable iff (!rstn)
    start_go && cfg.blk == dtbls_pkg::BLK_NONE && sy.a01 &&
    !sy.lword_n |=> lane_en == 4'h6 && cyc_kind == dtbls_pkg::CYC_DOUBLE)
    else $error("lword low with a01 high not decoded as bytes 1-2");

  // even single byte
  a_even_byte: assert property (
    @(posedge clk) disable iff (!rstn)
    start_go && cfg.blk == dtbls_pkg::BLK_NONE && !sy.ds1_n &&
    sy.ds0_n && sy.lword_n |=> lane_en == ($past(sy.a01) ? 4'h4 : 4'h1))
    else $error("even byte select wrong");

  // odd single byte
  a_odd_byte: assert property (
    @(posedge clk) disable iff (!rstn)
    start_go && cfg.blk == dtbls_pkg::BLK_NONE && sy.ds1_n &&
    !sy.ds0_n && sy.lword_n |=> lane_en == ($past(sy.a01) ? 4'h8 : 4'h2))
    else $error("odd byte select wrong");

  // no start while lines are still moving
  a_settle_wait: assert property (
    @(posedge clk) disable iff (!rstn)
    $changed(sy) |=> !xfer_start [*4])
    else $error("transfer started before lines settled");

  // bus timer fires on its last count
  a_timer_fire: assert property (
    @(posedge clk) disable iff (!rstn)
    bt_run && !berr_oe && bt_cnt_reg == BW'(BTO_CYC - 1) |=>
    berr_oe && !berr_out)
    else $error("bus timer did not drive bus error");

  // single-byte block steps one byte after the first transfer
  a_blk_step: assert property (
    @(posedge clk) disable iff (!rstn)
    start_go && !first_reg && cfg.blk == dtbls_pkg::BLK_BYTE |=>
    lane_en == 4'(4'h1 << $past(ptr_reg)) && ptr_reg == $past(ptr_reg) + 2'h1)
    else $error("single byte block did not step one lane");

  // monitor hit two cycles after a matching start
  a_mon_hit: assert property (
    @(posedge clk) disable iff (!rstn)
    start_go && (((sy.addr ^ cfg.mon_base) & ~cfg.mon_mask) == 30'h0) &&
    ((lanes_next & cfg.mon_lanes) != 4'h0) ##1 $stable(cfg) |=> mon_hit)
    else $error("location monitor missed a watched access");
endmodule : dtbls_lane_select

// ===== sim/dtbls_bm.sv
// bus master model that drives the backplane lines of the slave
`timescale 1ns/1ps
module dtbls_bm (
  // clock
  input wire logic clk,
  // open-drain bus error from the slave
  input wire logic berr_out,
  input wire logic berr_oe,
  // backplane lines
  output dtbls_pkg::dtbls_pins_s pins
);
  dtbls_pkg::dtbls_pins_s drv = '1;

  // bus error line sits on a pull-up unless the slave pulls it
  always_comb begin
    pins = drv;
    pins.berr_n = berr_oe ? berr_out : 1'b1;
  end

  // group address and address strobe
  task automatic addr_on(input logic [29:0] a);
    @(posedge clk);
    #1;
    drv.addr = a;
    drv.as_n = 1'b0;
  endtask : addr_on

  // lines as {ds1_n, ds0_n, a01, lword_n}; both strobes high is address-only
  task automatic lines(input logic [3:0] c);
    @(posedge clk);
    #1;
    {drv.ds1_n, drv.ds0_n, drv.a01, drv.lword_n} = c;
  endtask : lines

  // acknowledge of the answering slave, open drain
  task automatic ack(input logic l);
    @(posedge clk);
    #1;
    drv.dtack_n = l;
  endtask : ack

  // strobes up after an ack; a01 is no longer valid so it flips
  task automatic strobes_up();
    @(posedge clk);
    #1;
    drv.ds1_n = 1'b1;
    drv.ds0_n = 1'b1;
    drv.a01 = ~drv.a01;
  endtask : strobes_up

  // end of cycle: released lines float high on the bus terminators
  task automatic release_all();
    @(posedge clk);
    #1;
    drv = '1;
  endtask : release_all

  // the master waits for an acknowledge or a bus error, bounded
  task automatic wait_resp(input int n, output logic got);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++) begin
      @(posedge clk);
      got = (pins.dtack_n === 1'b0) || (pins.berr_n === 1'b0);
    end
  endtask : wait_resp
endmodule : dtbls_bm

// ===== sim/testbench.sv
// self-checking bench for the byte lane selector
`timescale 1ns/1ps
module testbench;
  localparam int BTO = 20;
  localparam logic [3:0] CODE [12] = '{4'h5, 4'h7, 4'h9, 4'hB, 4'h1,
    4'h3, 4'h0, 4'h4, 4'h8, 4'h2, 4'hA, 4'h6};
  localparam logic [3:0] LANE [12] = '{4'h1, 4'h4, 4'h2, 4'h8, 4'h3,
    4'hC, 4'hF, 4'h7, 4'hE, 4'h6, 4'h6, 4'h6};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  dtbls_pkg::dtbls_pins_s bus_pins;
  dtbls_pkg::dtbls_cfg_s cfg = '0;
  logic [3:0] lane_en;
  logic xfer_start, xfer_active, illegal_seen, berr_out, berr_oe, mon_hit;
  dtbls_pkg::dtbls_cyc_e cyc_kind;
  logic [29:0] xfer_addr;
  int mismatches = 0;
  int checks = 0;
  logic ok;
  int n;

  // device under test and the bus master model
  dtbls_lane_select #(
    .SETTLE_CYC(4),
    .BTO_CYC(BTO)
  ) dtbls_lane_select_inst (
    .clk(clk),
    .rstn(rstn),
    .bus_pins(bus_pins),
    .cfg(cfg),
    .lane_en(lane_en),
    .xfer_start(xfer_start),
    .xfer_active(xfer_active),
    .cyc_kind(cyc_kind),
    .xfer_addr(xfer_addr),
    .illegal_seen(illegal_seen),
    .berr_out(berr_out),
    .berr_oe(berr_oe),
    .mon_hit(mon_hit)
  );
  dtbls_bm dtbls_bm_inst (
    .clk(clk),
    .berr_out(berr_out),
    .berr_oe(berr_oe),
    .pins(bus_pins)
  );

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t ns: got %0h, expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  function automatic dtbls_pkg::dtbls_cyc_e kind_of(input logic [3:0] l);
    case ($countones(l))
      1: return dtbls_pkg::CYC_SINGLE;
      2: return dtbls_pkg::CYC_DOUBLE;
      3: return dtbls_pkg::CYC_TRIPLE;
      default: return dtbls_pkg::CYC_QUAD;
    endcase
  endfunction : kind_of

  // bounded waits for a start and for the return to idle
  task automatic wait_start();
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(negedge clk);
      ok = (xfer_start === 1'b1);
    end
    chk(ok, 1);
  endtask : wait_start

  task automatic wait_idle();
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(negedge clk);
      ok = (xfer_active === 1'b0) && (lane_en === 4'h0);
    end
    chk(ok, 1);
  endtask : wait_idle

  task automatic set_mon(input logic [29:0] b, input logic [29:0] m,
      input logic [3:0] l);
    @(posedge clk);
    #1;
    cfg.mon_base = b;
    cfg.mon_mask = m;
    cfg.mon_lanes = l;
  endtask : set_mon

  // one plain transfer, judged at the start and the pulse after it
  task automatic xfer(input logic [29:0] a, input logic [3:0] c,
      input logic [3:0] lane, input logic ill, input logic hit);
    dtbls_bm_inst.addr_on(a);
    dtbls_bm_inst.lines(c);
    wait_start();
    chk(lane_en, lane);
    chk(cyc_kind, kind_of(lane));
    chk(illegal_seen, ill);
    chk(xfer_addr, a);
    @(negedge clk);
    chk(mon_hit, hit);
    dtbls_bm_inst.ack(1'b0);
    dtbls_bm_inst.release_all();
    wait_idle();
  endtask : xfer

  task automatic t_decode();
    for (int i = 0; i < 12; i++) begin
      xfer(30'h1230 + i, CODE[i], LANE[i], i >= 10, 1'b0);
    end
  endtask : t_decode

  task automatic t_addr_only();
    dtbls_bm_inst.addr_on(30'h155);
    for (int i = 0; i < 4; i++) begin
      dtbls_bm_inst.lines({2'b11, i[1:0]});
      repeat (10) begin
        @(negedge clk);
        chk({xfer_active, xfer_start, lane_en}, 0);
      end
    end
    dtbls_bm_inst.release_all();
  endtask : t_addr_only

  // second strobe falls two cycles after the first
  task automatic t_skew(input logic [3:0] c1, input logic [3:0] c2,
      input logic [3:0] lane);
    dtbls_bm_inst.addr_on(30'h2A);
    dtbls_bm_inst.lines(c1);
    @(posedge clk);
    dtbls_bm_inst.lines(c2);
    wait_start();
    chk(lane_en, lane);
    chk(illegal_seen, 0);
    dtbls_bm_inst.ack(1'b0);
    dtbls_bm_inst.release_all();
    wait_idle();
  endtask : t_skew

  // four transfers under one address strobe, first line code in c[15:12]
  task automatic t_block(input dtbls_pkg::dtbls_blk_e b,
      input logic [15:0] c, input logic [15:0] l,
      input dtbls_pkg::dtbls_cyc_e k);
    @(posedge clk);
    #1;
    cfg.blk = b;
    dtbls_bm_inst.addr_on(30'h3C0);
    for (int i = 3; i >= 0; i--) begin
      dtbls_bm_inst.lines(c[i*4 +: 4]);
      wait_start();
      chk(lane_en, l[i*4 +: 4]);
      chk(cyc_kind, k);
      dtbls_bm_inst.ack(1'b0);
      dtbls_bm_inst.strobes_up();
      dtbls_bm_inst.ack(1'b1);
      wait_idle();
    end
    dtbls_bm_inst.release_all();
    @(posedge clk);
    #1;
    cfg.blk = dtbls_pkg::BLK_NONE;
  endtask : t_block

  // no answer: bus error after the timer span, held until strobes rise
  task automatic t_timeout();
    dtbls_bm_inst.addr_on(30'h1F);
    dtbls_bm_inst.lines(4'h1);
    for (n = 0; n < 3 * BTO && berr_oe !== 1'b1; n++) @(negedge clk);
    chk(n >= BTO && n <= BTO + 6, 1);
    chk(berr_out, 0);
    dtbls_bm_inst.wait_resp(4, ok);
    chk(ok, 1);
    dtbls_bm_inst.release_all();
    wait_idle();
    chk(berr_oe, 0);
  endtask : t_timeout

  // a slow slave that answers inside the span sees no bus error
  task automatic t_slow_ack();
    dtbls_bm_inst.addr_on(30'h2F);
    dtbls_bm_inst.lines(4'h1);
    repeat (BTO - 10) @(negedge clk);
    dtbls_bm_inst.ack(1'b0);
    repeat (2 * BTO) begin
      @(negedge clk);
      chk(berr_oe, 0);
    end
    dtbls_bm_inst.release_all();
    wait_idle();
  endtask : t_slow_ack

  // watchdog against a hang
  initial begin
    #20000;
    mismatches++;
    $display("Error at %0t ns: watchdog expired", $time);
    finish_test();
  end

  // reset, then the scenarios
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(negedge clk);
    chk({lane_en, xfer_active, berr_oe, mon_hit, cyc_kind}, 0);
    repeat (8) @(posedge clk);
    t_decode();
    t_decode();
    t_addr_only();
    t_skew(4'hA, 4'h2, 4'h6);
    t_skew(4'h4, 4'h0, 4'hF);
    t_block(dtbls_pkg::BLK_BYTE, 16'h797B, 16'h4812,
      dtbls_pkg::CYC_BLK_BYTE);
    t_block(dtbls_pkg::BLK_DBL, 16'h3311, 16'hC3C3,
      dtbls_pkg::CYC_BLK_DBL);
    t_block(dtbls_pkg::BLK_NONE, 16'h0000, 16'hFFFF,
      dtbls_pkg::CYC_QUAD);
    t_timeout();
    t_slow_ack();
    set_mon(30'h2468, 30'h0, 4'h1);
    xfer(30'h2468, 4'h5, 4'h1, 1'b0, 1'b1);
    xfer(30'h2468, 4'h9, 4'h2, 1'b0, 1'b0);
    xfer(30'h2469, 4'h5, 4'h1, 1'b0, 1'b0);
    set_mon(30'h2468, 30'h1, 4'h3);
    xfer(30'h2469, 4'h9, 4'h2, 1'b0, 1'b1);
    finish_test();
  end
endmodule : testbench
